/* File: src/bkrc_consts.svh */
// constants for the buck regulator configuration block
`ifndef BKRC_CONSTS_SVH
`define BKRC_CONSTS_SVH
`define BKRC_A_NORM     8'h20
`define BKRC_A_STBY     8'h21
`define BKRC_A_SLEEP    8'h22
`define BKRC_A_MODE     8'h23
`define BKRC_A_CONF     8'h24
`define BKRC_B_NORM     8'h2E
`define BKRC_B_STBY     8'h2F
`define BKRC_B_SLEEP    8'h30
`define BKRC_B_MODE     8'h31
`define BKRC_B_CONF     8'h32
`define BKRC_T_NORM     8'h35
`define BKRC_T_STBY     8'h36
`define BKRC_T_SLEEP    8'h37
`define BKRC_T_MODE     8'h38
`define BKRC_T_CONF     8'h39
`define BKRC_C_FIRST    8'h3C
`define BKRC_C_LAST     8'h40
`define BKRC_MODE_RST   4'h8
`define BKRC_FREQ_1M    2'h0
`define BKRC_FREQ_2M    2'h1
`define BKRC_FREQ_4M    2'h2
`define BKRC_FREQ_RSV   2'h3
`define BKRC_PH_0       2'h0
`define BKRC_PH_90      2'h1
`define BKRC_PH_180     2'h2
`define BKRC_PH_270     2'h3
`define BKRC_TOPO_ONE   2'h1
`define BKRC_TOPO_TWO   2'h3
`define BKRC_CONF_DVS   6
`define BKRC_CONF_PH    4
`define BKRC_CONF_FREQ  2
`define BKRC_CONF_CURRENT_LIMIT  0
`define BKRC_MV_A_BASE  16'd700
`define BKRC_MV_A_STEP  16'd25
`define BKRC_CODE_LIN   5'd29
`define BKRC_CODE_30    5'h1E
`define BKRC_MV_B_30    16'd1450
`define BKRC_MV_B_31    16'd1475
`define BKRC_MV_A_30    16'd1800
`define BKRC_MV_A_31    16'd3300
`define BKRC_MV_T_BASE  16'd1500
`define BKRC_MV_T_STEP  16'd50
`define BKRC_MV_H_0     16'd2500
`define BKRC_MV_H_1     16'd2800
`define BKRC_MV_H_2     16'd2850
`define BKRC_MV_H_3     16'd3000
`define BKRC_MV_H_4     16'd3100
`define BKRC_MV_H_5     16'd3150
`define BKRC_MV_H_6     16'd3200
`define BKRC_MV_H_7     16'd3300
`define BKRC_PER_1M     5'h1F
`define BKRC_PER_2M     5'h0F
`define BKRC_PER_4M     5'h07
`define BKRC_QCNT_MAX   5'd31
`endif

/* File: src/bkrc_pkg.sv */
// types for the buck regulator configuration block
package bkrc_pkg;
    typedef enum logic [1:0] {BKRC_NORMAL, BKRC_STANDBY, BKRC_SLEEP}
        bkrc_opmode_e;
    typedef struct packed {
        logic [4:0] norm;
        logic [4:0] stby;
        logic [4:0] sleep;
        logic [3:0] mode;
        logic       voltage_scaling_speed;
        logic [1:0] phase;
        logic [1:0] freq;
    } bkrc_pair_s;
    typedef struct packed {
        logic [2:0] norm;
        logic [2:0] stby;
        logic [2:0] sleep;
        logic [3:0] mode;
        logic       voltage_scaling_speed;
        logic [1:0] phase;
        logic [1:0] freq;
        logic [1:0] current_limit;
    } bkrc_two_s;
    typedef struct packed {
        bkrc_pair_s a;
        bkrc_pair_s b;
        bkrc_two_s  t;
        logic [4:0] qcnt;
        logic       loaded;
        logic [7:0] rdata;
    } bkrc_state_s;
    typedef struct packed {
        logic [15:0] mv;
        logic [3:0]  mode;
        logic [1:0]  freq;
        logic [1:0]  phase;
        logic        voltage_scaling_speed;
        logic        enable;
    } bkrc_reg_out_s;
endpackage

/* File: src/bkrc_top.sv */
// buck regulator configuration register bank and clock phase logic
//
// Function
// - phase code picks 0, 90, 90, 270 degrees
// - reset phases: pair 0, buck two 90
// - frequency code 1, 2 default, 4 MHz
// - any phase usable with any frequency
// - topology fuse: 01 single, 11 independent
// - single phase uses first half settings only
// - independent halves use their own settings
// - pair codes 0-29 are 700mV plus 25mV
// - codes 30, 31 differ per half
// - each half has normal, standby, sleep points
// - default voltage fuses share set-point encoding
// - buck two low range 1.5V plus 50mV
// - buck two high range table lookup
// - writes cannot change buck two range
// - buck two has three set-point fields
// - first half registers at 0x20-0x24
// - second half registers at 0x2E-0x32
// - buck two registers at 0x35-0x39
// - all registers reached over control bus
// - third buck block occupies 0x3C-0x40
`timescale 1ns/100ps
`include "bkrc_consts.svh"
module bkrc_top
    import bkrc_pkg::*;
#(
    parameter int QCNT_W = 5
)(
    input  wire logic          ref_clk_i,     // 100 MHz clock
    input  wire logic          resetn_i,      // async reset, low
    input  wire logic          wr_i,          // register write strobe
    input  wire logic          rd_i,          // register read strobe
    input  wire logic [7:0]    addr_i,        // register address
    input  wire logic [7:0]    wdata_i,       // write data
    output logic [7:0]         rdata_o,       // read data, registered
    output logic               rvalid_o,      // read data valid pulse
    input  wire logic [1:0]    topo_fuse_i,   // pair topology fuse
    input  wire logic          range_fuse_i,  // buck two range fuse
    input  wire logic [4:0]    a_dflt_fuse_i, // half a default code
    input  wire logic [4:0]    b_dflt_fuse_i, // half b default code
    input  wire logic [2:0]    t_dflt_fuse_i, // buck two default code
    input  wire logic          fuse_load_i,   // fuse copy pulse
    input  wire logic [1:0]    opmode_i,      // normal/standby/sleep
    output bkrc_reg_out_s      a_out_o,       // half a / combined
    output bkrc_reg_out_s      b_out_o,       // half b
    output bkrc_reg_out_s      t_out_o,       // buck two
    output logic [2:0]         sw_clk_o,      // a, b, two switch clocks
    output logic               single_o       // pair single phase
);
    bkrc_state_s st;
    bkrc_state_s next_st;
    logic        rvalid;
    logic [1:0]  opm_q1;
    logic [1:0]  opm_q2;
    logic        single;
    logic [2:0]  next_clk;
    logic [2:0]  clk_q;

    function automatic logic [1:0] fix_freq(input logic [1:0] f);
        fix_freq = (f == `BKRC_FREQ_RSV) ? `BKRC_FREQ_2M : f;
    endfunction

    // quarter index of the wave edge for a phase code; code 10 stays 90
    function automatic logic [1:0] ph_q(input logic [1:0] p);
        unique case (p)
            `BKRC_PH_0:   ph_q = 2'h0;
            `BKRC_PH_90:  ph_q = 2'h1;
            `BKRC_PH_180: ph_q = 2'h1;
            `BKRC_PH_270: ph_q = 2'h3;
        endcase
    endfunction

    // one switch clock from the common timebase, any phase with any freq
    function automatic logic sw_wave(input logic [4:0] q,
                                     input logic [1:0] f,
                                     input logic [1:0] p);
        logic [4:0] per;
        logic [4:0] sh;
        per = 5'h0;
        sh  = 5'h0;
        // timebase counts 4 MHz eighths; 1 MHz is 32 slots
        unique case (fix_freq(f))
            `BKRC_FREQ_1M:
            begin
                per = `BKRC_PER_1M;
                sh  = {ph_q(p), 3'h0};
            end
            `BKRC_FREQ_4M:
            begin
                per = `BKRC_PER_4M;
                sh  = {2'h0, ph_q(p), 1'h0};
            end
            default:
            begin
                per = `BKRC_PER_2M;
                sh  = {1'h0, ph_q(p), 2'h0};
            end
        endcase
        sw_wave = ((q - sh) & per) <= (per >> 1);
    endfunction

    function automatic logic [15:0] pair_mv(input logic [4:0] c,
                                           input logic first);
        if (c <= `BKRC_CODE_LIN)
            pair_mv = `BKRC_MV_A_BASE + `BKRC_MV_A_STEP * {11'h0, c};
        else if (c == `BKRC_CODE_30)
            pair_mv = first ? `BKRC_MV_A_30 : `BKRC_MV_B_30;
        else
            pair_mv = first ? `BKRC_MV_A_31 : `BKRC_MV_B_31;
    endfunction

    function automatic logic [15:0] two_mv(input logic [2:0] c,
                                          input logic hi);
        logic [15:0] tab [8];
        tab = '{`BKRC_MV_H_0, `BKRC_MV_H_1, `BKRC_MV_H_2, `BKRC_MV_H_3,
                `BKRC_MV_H_4, `BKRC_MV_H_5, `BKRC_MV_H_6, `BKRC_MV_H_7};
        if (hi)
            two_mv = tab[c];
        else
            two_mv = `BKRC_MV_T_BASE + `BKRC_MV_T_STEP * {13'h0, c};
    endfunction

    function automatic logic [4:0] pick5(input bkrc_pair_s r,
                                         input logic [1:0] m);
        unique case (m)
            BKRC_STANDBY: pick5 = r.stby;
            BKRC_SLEEP:   pick5 = r.sleep;
            default:      pick5 = r.norm;
        endcase
    endfunction

    function automatic logic [2:0] pick3(input bkrc_two_s r,
                                         input logic [1:0] m);
        unique case (m)
            BKRC_STANDBY: pick3 = r.stby;
            BKRC_SLEEP:   pick3 = r.sleep;
            default:      pick3 = r.norm;
        endcase
    endfunction

    function automatic logic [7:0] conf_pair(input bkrc_pair_s r);
        conf_pair = {1'h0, r.voltage_scaling_speed, r.phase, r.freq, 2'h0};
    endfunction

    assign single = (topo_fuse_i == `BKRC_TOPO_ONE);

    always_comb
    begin
        next_st = st;
        next_st.qcnt = st.qcnt + 5'h1;
        // fuse copy once after reset; defaults share run-time encoding
        if (fuse_load_i && !st.loaded)
        begin
            next_st.loaded  = 1'h1;
            next_st.a.norm  = a_dflt_fuse_i;
            next_st.b.norm  = b_dflt_fuse_i;
            next_st.t.norm  = t_dflt_fuse_i;
        end
        // range never stored: the fuse alone decides it
        if (wr_i)
        begin
            unique case (addr_i)
                `BKRC_A_NORM:  next_st.a.norm  = wdata_i[4:0];
                `BKRC_A_STBY:  next_st.a.stby  = wdata_i[4:0];
                `BKRC_A_SLEEP: next_st.a.sleep = wdata_i[4:0];
                `BKRC_A_MODE:  next_st.a.mode  = wdata_i[3:0];
                `BKRC_A_CONF:
                begin
                    next_st.a.voltage_scaling_speed   = wdata_i[`BKRC_CONF_DVS];
                    next_st.a.phase = wdata_i[`BKRC_CONF_PH +: 2];
                    next_st.a.freq  = fix_freq(wdata_i[`BKRC_CONF_FREQ +: 2]);
                end
                `BKRC_B_NORM:  next_st.b.norm  = wdata_i[4:0];
                `BKRC_B_STBY:  next_st.b.stby  = wdata_i[4:0];
                `BKRC_B_SLEEP: next_st.b.sleep = wdata_i[4:0];
                `BKRC_B_MODE:  next_st.b.mode  = wdata_i[3:0];
                `BKRC_B_CONF:
                begin
                    next_st.b.voltage_scaling_speed   = wdata_i[`BKRC_CONF_DVS];
                    next_st.b.phase = wdata_i[`BKRC_CONF_PH +: 2];
                    next_st.b.freq  = fix_freq(wdata_i[`BKRC_CONF_FREQ +: 2]);
                end
                `BKRC_T_NORM:  next_st.t.norm  = wdata_i[2:0];
                `BKRC_T_STBY:  next_st.t.stby  = wdata_i[2:0];
                `BKRC_T_SLEEP: next_st.t.sleep = wdata_i[2:0];
                `BKRC_T_MODE:  next_st.t.mode  = wdata_i[3:0];
                `BKRC_T_CONF:
                begin
                    next_st.t.voltage_scaling_speed   = wdata_i[`BKRC_CONF_DVS];
                    next_st.t.phase = wdata_i[`BKRC_CONF_PH +: 2];
                    next_st.t.freq  = fix_freq(wdata_i[`BKRC_CONF_FREQ +: 2]);
                    next_st.t.current_limit  = wdata_i[`BKRC_CONF_CURRENT_LIMIT +: 2];
                end
                default: ;
            endcase
        end
        next_st.rdata = 8'h00;
        // third buck range is not decoded here; its reads fall to the zero default
        if (rd_i)
        begin
            unique case (addr_i)
                `BKRC_A_NORM:  next_st.rdata = {3'h0, st.a.norm};
                `BKRC_A_STBY:  next_st.rdata = {3'h0, st.a.stby};
                `BKRC_A_SLEEP: next_st.rdata = {3'h0, st.a.sleep};
                `BKRC_A_MODE:  next_st.rdata = {4'h0, st.a.mode};
                `BKRC_A_CONF:  next_st.rdata = conf_pair(st.a);
                `BKRC_B_NORM:  next_st.rdata = {3'h0, st.b.norm};
                `BKRC_B_STBY:  next_st.rdata = {3'h0, st.b.stby};
                `BKRC_B_SLEEP: next_st.rdata = {3'h0, st.b.sleep};
                `BKRC_B_MODE:  next_st.rdata = {4'h0, st.b.mode};
                `BKRC_B_CONF:  next_st.rdata = conf_pair(st.b);
                `BKRC_T_NORM:  next_st.rdata = {5'h0, st.t.norm};
                `BKRC_T_STBY:  next_st.rdata = {5'h0, st.t.stby};
                `BKRC_T_SLEEP: next_st.rdata = {5'h0, st.t.sleep};
                `BKRC_T_MODE:  next_st.rdata = {4'h0, st.t.mode};
                `BKRC_T_CONF:
                    next_st.rdata = {1'h0, st.t.voltage_scaling_speed, st.t.phase,
                                     st.t.freq, st.t.current_limit};
                default:       next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st         <= '0;
            st.a.mode  <= `BKRC_MODE_RST;
            st.b.mode  <= `BKRC_MODE_RST;
            st.t.mode  <= `BKRC_MODE_RST;
            st.a.freq  <= `BKRC_FREQ_2M;
            st.b.freq  <= `BKRC_FREQ_2M;
            st.t.freq  <= `BKRC_FREQ_2M;
            st.a.phase <= `BKRC_PH_0;
            st.b.phase <= `BKRC_PH_0;
            st.t.phase <= `BKRC_PH_90;
            rvalid     <= 1'h0;
            opm_q1     <= 2'h0;
            opm_q2     <= 2'h0;
            clk_q      <= 3'h0;
        end
        else
        begin
            st     <= next_st;
            rvalid <= rd_i;
            opm_q1 <= opmode_i;
            opm_q2 <= opm_q1;
            clk_q  <= next_clk;
        end
    end

    // in single phase both halves switch off the first half's settings
    logic [1:0] ch_freq  [3];
    logic [1:0] ch_phase [3];

    assign ch_freq[0]  = st.a.freq;
    assign ch_phase[0] = st.a.phase;
    assign ch_freq[1]  = single ? st.a.freq : st.b.freq;
    assign ch_phase[1] = single ? st.a.phase : st.b.phase;
    assign ch_freq[2]  = st.t.freq;
    assign ch_phase[2] = st.t.phase;

    for (genvar ch = 0; ch < 3; ch++)
    begin : g_sw_clk
        assign next_clk[ch] = sw_wave(st.qcnt, ch_freq[ch], ch_phase[ch]);
    end

    always_comb
    begin
        a_out_o.mv     = pair_mv(pick5(st.a, opm_q2), 1'h1);
        a_out_o.mode   = st.a.mode;
        a_out_o.freq   = st.a.freq;
        a_out_o.phase  = st.a.phase;
        a_out_o.voltage_scaling_speed    = st.a.voltage_scaling_speed;
        a_out_o.enable = 1'h1;
        // second half idles in single phase; its registers stay readable
        b_out_o.mv     = pair_mv(pick5(single ? st.a : st.b, opm_q2),
                                 single);
        b_out_o.mode   = single ? st.a.mode : st.b.mode;
        b_out_o.freq   = ch_freq[1];
        b_out_o.phase  = ch_phase[1];
        b_out_o.voltage_scaling_speed    = single ? st.a.voltage_scaling_speed : st.b.voltage_scaling_speed;
        b_out_o.enable = !single;
        t_out_o.mv     = two_mv(pick3(st.t, opm_q2), range_fuse_i);
        t_out_o.mode   = st.t.mode;
        t_out_o.freq   = st.t.freq;
        t_out_o.phase  = st.t.phase;
        t_out_o.voltage_scaling_speed    = st.t.voltage_scaling_speed;
        t_out_o.enable = 1'h1;
    end

    assign rdata_o  = st.rdata;
    assign rvalid_o = rvalid;
    assign sw_clk_o = clk_q;
    assign single_o = single;
endmodule // bkrc_top

/* File: test/bkrc_host.sv */
// host model: drives the register strobes as the control bus would
`timescale 1ns/100ps
module bkrc_host (
    input  wire logic  ref_clk_i, // bench clock
    output logic       wr_o,      // write strobe
    output logic       rd_o,      // read strobe
    output logic [7:0] addr_o,    // register address
    output logic [7:0] wdata_o    // write data
);
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // idle address and data lines show inverted values so stale data is never trusted
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        wr_o = w;
        rd_o = !w;
        addr_o = a;
        wdata_o = d;
        @(posedge ref_clk_i);
        #1;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // bkrc_host

/* File: test/bkrc_checker_assertions.sv */
// port assertions for the buck regulator configuration block
`timescale 1ns/100ps
`include "bkrc_consts.svh"
module bkrc_checker
    import bkrc_pkg::*;
(
    input wire logic          ref_clk_i,    // clock
    input wire logic          resetn_i,     // reset, low
    input wire logic          wr_i,         // write strobe
    input wire logic          rd_i,         // read strobe
    input wire logic [7:0]    addr_i,       // address
    input wire logic [7:0]    wdata_i,      // write data
    input wire logic [7:0]    rdata_o,      // read data
    input wire logic          rvalid_o,     // read valid
    input wire logic [1:0]    topo_fuse_i,  // topology fuse
    input wire logic          range_fuse_i, // range fuse
    input wire bkrc_reg_out_s a_out_o,      // half a
    input wire bkrc_reg_out_s b_out_o,      // half b
    input wire bkrc_reg_out_s t_out_o,      // buck two
    input wire logic [2:0]    sw_clk_o,     // switch clocks
    input wire logic          single_o      // single phase
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    function automatic logic pair_ok(input logic [15:0] m,
                                     input logic [15:0] top);
        return m >= `BKRC_MV_A_BASE && m <= top &&
            (m - `BKRC_MV_A_BASE) % `BKRC_MV_A_STEP == 16'h0000;
    endfunction
    property p_rd_answer;
        rd_i |=> rvalid_o ##1 (!rvalid_o || $past(rd_i));
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe got no single answer");
    property p_third_buck;
        rd_i && addr_i >= `BKRC_C_FIRST && addr_i <= `BKRC_C_LAST
            |=> rdata_o == 8'h00;
    endproperty
    a_third_buck: assert property (p_third_buck)
        else $error("third buck read not zero");
    property p_single;
        single_o == (topo_fuse_i == `BKRC_TOPO_ONE);
    endproperty
    a_single: assert property (p_single)
        else $error("topology flag wrong");
    property p_follow;
        single_o |-> b_out_o.freq == a_out_o.freq &&
            b_out_o.phase == a_out_o.phase && b_out_o.mv == a_out_o.mv;
    endproperty
    a_follow: assert property (p_follow)
        else $error("combined output ignores half a");
    property p_a_mv;
        pair_ok(a_out_o.mv, 16'h0591) || a_out_o.mv == `BKRC_MV_A_30 ||
            a_out_o.mv == `BKRC_MV_A_31;
    endproperty
    a_a_mv: assert property (p_a_mv)
        else $error("half a voltage off the code table");
    property p_b_mv;
        !single_o |-> pair_ok(b_out_o.mv, `BKRC_MV_B_31);
    endproperty
    a_b_mv: assert property (p_b_mv)
        else $error("half b voltage off the code table");
    property p_t_low;
        !range_fuse_i |-> t_out_o.mv >= `BKRC_MV_T_BASE &&
            t_out_o.mv <= 16'h073A &&
            (t_out_o.mv - `BKRC_MV_T_BASE) % `BKRC_MV_T_STEP == 16'h0000;
    endproperty
    a_t_low: assert property (p_t_low)
        else $error("buck two left its low range");
    property p_freq_rsv;
        wr_i && addr_i == `BKRC_A_CONF && wdata_i[3:2] == `BKRC_FREQ_RSV
            |=> a_out_o.freq == `BKRC_FREQ_2M;
    endproperty
    a_freq_rsv: assert property (p_freq_rsv)
        else $error("reserved frequency not replaced");
    // same settings one cycle back must give the same switch clock
    property p_same_clk;
        $past({a_out_o.freq, a_out_o.phase, a_out_o.enable}) ==
            $past({b_out_o.freq, b_out_o.phase, b_out_o.enable})
            |-> sw_clk_o[0] == sw_clk_o[1];
    endproperty
    a_same_clk: assert property (p_same_clk)
        else $error("equal settings give different clocks");
endmodule // bkrc_checker
bind bkrc_top bkrc_checker i_bkrc_checker (.ref_clk_i, .resetn_i, .wr_i,
    .rd_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o, .topo_fuse_i,
    .range_fuse_i, .a_out_o, .b_out_o, .t_out_o, .sw_clk_o, .single_o);

/* File: test/test_buck_regulator_config.sv */
// self-checking bench for the buck regulator configuration block
`timescale 1ns/100ps
`include "bkrc_consts.svh"
module test_buck_regulator_config
    import bkrc_pkg::*;
;
    logic          ref_clk_i = 1'b0, resetn_i = 1'b0, wr_i, rd_i, prev;
    logic [7:0]    addr_i, wdata_i, rdata_o, exp_q[$];
    logic          rvalid_o, single_o, range_fuse_i = 1'b0;
    logic          fuse_load_i = 1'b0;
    logic [1:0]    topo_fuse_i = 2'h3, opmode_i = 2'h0;
    logic [4:0]    a_dflt = 5'h05;
    logic [2:0]    sw_clk_o;
    bkrc_reg_out_s a_out_o, b_out_o, t_out_o;
    logic [15:0]   hi_mv [8] = '{16'h09C4, 16'h0AF0, 16'h0B22, 16'h0BB8,
                                 16'h0C1C, 16'h0C4E, 16'h0C80, 16'h0CE4};
    int            fail_count = 0, comparisons = 0, cycles = 0, k, j;
    integer        seed = 32'hBD0F;
    always #5 ref_clk_i = ~ref_clk_i;
    bkrc_host i_bkrc_host (.ref_clk_i, .wr_o(wr_i), .rd_o(rd_i),
        .addr_o(addr_i), .wdata_o(wdata_i));
    bkrc_top #(.QCNT_W(5)) i_bkrc_top (.ref_clk_i, .resetn_i, .wr_i, .rd_i,
        .addr_i, .wdata_i, .rdata_o, .rvalid_o, .topo_fuse_i, .range_fuse_i,
        .a_dflt_fuse_i(a_dflt), .b_dflt_fuse_i(5'h0A), .t_dflt_fuse_i(3'h3),
        .fuse_load_i, .opmode_i, .a_out_o, .b_out_o, .t_out_o, .sw_clk_o,
        .single_o);
    function automatic logic [7:0] reg_addr(input int n);
        return (n < 5 ? 8'h20 : n < 10 ? 8'h29 : 8'h2B) + 8'(n);
    endfunction
    function automatic logic [7:0] masked(input int n, input logic [7:0] v);
        logic [7:0] m;
        m = n % 5 == 3 ? 8'h0F : n % 5 == 4 ? (n == 14 ? 8'h7F : 8'h7C) :
            n > 9 ? 8'h07 : 8'h1F;
        m = m & v;
        if (n % 5 == 4 && m[3:2] == `BKRC_FREQ_RSV)
            m[3:2] = `BKRC_FREQ_2M;
        return m;
    endfunction
    function automatic logic [15:0] pair_mv(input int c, input logic first);
        if (c < 30)
            return `BKRC_MV_A_BASE + 16'(c) * `BKRC_MV_A_STEP;
        if (first)
            return c == 30 ? `BKRC_MV_A_30 : `BKRC_MV_A_31;
        return c == 30 ? `BKRC_MV_B_30 : `BKRC_MV_B_31;
    endfunction
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] s);
        comparisons++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_bkrc_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_bkrc_host.xfer(1'b1, a, v);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // read data stands one cycle, so it is taken at the edge after rvalid
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            stop_test;
        end
        if (rvalid_o === 1'b1)
            chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
    end
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        for (int n = 0; n < 15; n++)
            rchk(reg_addr(n), n % 5 == 3 ? 8'h08 : n % 5 < 3 ? 8'h00 :
                 n == 14 ? 8'h14 : 8'h04);
        for (int a = 8'h3C; a < 8'h42; a++)
        begin
            wr(8'(a), 8'hFF);
            rchk(8'(a), 8'h00);
        end
        repeat (2)
        begin
            @(posedge ref_clk_i);
            #1 fuse_load_i = 1'b1;
            @(posedge ref_clk_i);
            #1 fuse_load_i = 1'b0;
            a_dflt = 5'h1F;
        end
        rchk(`BKRC_A_NORM, 8'h05);
        rchk(`BKRC_B_NORM, 8'h0A);
        rchk(`BKRC_T_NORM, 8'h03);
        for (int f = 0; f < 3; f++)
        begin
            wr(`BKRC_A_CONF, 8'h10 | 8'(f << 2));
            wr(`BKRC_B_CONF, 8'h20 | 8'(f << 2));
            k = 0;
            j = 0;
            prev = sw_clk_o[0];
            repeat (32)
            begin
                @(posedge ref_clk_i);
                #1;
                k += int'(sw_clk_o[0] !== sw_clk_o[1]);
                j += int'(sw_clk_o[0] !== prev);
                prev = sw_clk_o[0];
            end
            chk("phase 01 against 10", 16'h0000, 16'(k));
            chk("clock toggles", 16'(2 << f), 16'(j));
        end
        wr(`BKRC_A_CONF, 8'h00);
        wr(`BKRC_B_CONF, 8'h14);
        wr(`BKRC_T_CONF, 8'h14);
        rchk(`BKRC_T_CONF, 8'h14);
        for (int c = 0; c < 32; c++)
        begin
            wr(`BKRC_A_NORM, 8'(c));
            wr(`BKRC_B_NORM, 8'(31 - c));
            chk("a mv", pair_mv(c, 1'b1), a_out_o.mv);
            chk("b mv", pair_mv(31 - c, 1'b0), b_out_o.mv);
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(`BKRC_T_NORM, 8'(c));
            chk("t mv", `BKRC_MV_T_BASE + 16'(c) * `BKRC_MV_T_STEP,
                t_out_o.mv);
        end
        wr(`BKRC_A_STBY, 8'h01);
        wr(`BKRC_A_SLEEP, 8'h02);
        for (int m = 1; m < 3; m++)
        begin
            opmode_i = 2'(m);
            repeat (4) @(posedge ref_clk_i);
            #1;
            chk("a mv by opmode", pair_mv(m, 1'b1), a_out_o.mv);
        end
        opmode_i = BKRC_NORMAL;
        repeat (40)
        begin
            k = int'({$random(seed)} % 15);
            wdata_i_rand: wr(reg_addr(k), 8'($random(seed)));
            rchk(reg_addr(k), masked(k, ~wdata_i));
        end
        @(posedge ref_clk_i);
        #1 resetn_i = 1'b0;
        topo_fuse_i = `BKRC_TOPO_ONE;
        range_fuse_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        chk("single", 16'h0001, {15'h0000, single_o});
        wr(`BKRC_A_CONF, 8'h28);
        wr(`BKRC_A_NORM, 8'h1E);
        chk("b freq", 16'h0002, {14'h0000, b_out_o.freq});
        chk("b mv", `BKRC_MV_A_30, b_out_o.mv);
        chk("b phase", 16'h0002, {14'h0000, b_out_o.phase});
        chk("b enable", 16'h0000, {15'h0000, b_out_o.enable});
        wr(`BKRC_B_CONF, 8'h28);
        for (int c = 0; c < 8; c++)
        begin
            wr(`BKRC_T_NORM, 8'(c));
            chk("t high mv", hi_mv[c], t_out_o.mv);
        end
        wr(`BKRC_T_CONF, 8'hFF);
        chk("t range kept", hi_mv[7], t_out_o.mv);
        chk("t freq", 16'h0001, {14'h0000, t_out_o.freq});
        rchk(`BKRC_T_CONF, 8'h77);
        repeat (3) @(posedge ref_clk_i);
        chk("reads answered", 16'h0000, 16'(exp_q.size()));
        stop_test;
    end
endmodule // test_buck_regulator_config
